// file: core/ufa_addr_match.sv
// given and broadcast address comparison
`timescale 1ns/1ps
module ufa_addr_match (
   // address byte and node setup
   input  wire logic [7:0] rx_byte_i,
   input  wire logic [7:0] node_address_i,
   input  wire logic [7:0] node_address_mask_i,
   // result
   output logic            hit_o
);
   logic [7:0] bcast;
   logic       given_hit;
   logic       bcast_hit;

   // zero mask bits are don't-care in the given address
   assign given_hit = ((rx_byte_i ^ node_address_i) & node_address_mask_i) == 8'h00;
   // broadcast is address or mask, zeros are don't-care
   assign bcast     = node_address_i | node_address_mask_i;
   assign bcast_hit = ((rx_byte_i ^ bcast) & bcast) == 8'h00;
   // an all-ones mask leaves only the exact address and broadcast
   assign hit_o     = given_hit || bcast_hit;
endmodule

// file: core/ufa_pkg.sv
// shared constants and types of the serial receive checker
package ufa_pkg;
   // register indices on the plain register port
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_DATA   = 3'h1;
   localparam logic [2:0] REG_POWER  = 3'h2;
   localparam logic [2:0] REG_ADDR   = 3'h3;
   localparam logic [2:0] REG_MASK   = 3'h4;
   // serial control register fields
   localparam int CTRL_MODE_LOW  = 7;
   localparam int CTRL_MODE_HIGH = 6;
   localparam int CTRL_MULTIDROP = 5;
   localparam int CTRL_RX_EN     = 4;
   localparam int CTRL_TX_NINTH  = 3;
   localparam int CTRL_RX_NINTH  = 2;
   localparam int CTRL_TX_DONE   = 1;
   localparam int CTRL_RX_DONE   = 0;
   // power control register field
   localparam int POWER_FRAME_CHECK = 6;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // timing: ticks are 16x oversampling enables in the async modes
   localparam logic [3:0] LAST_TICK  = 4'hf;
   localparam logic [3:0] MID_TICK   = 4'h7;
   localparam logic [3:0] LAST_BIT8  = 4'h7;
   localparam logic [3:0] LAST_BIT9  = 4'h8;
   localparam logic [3:0] TX_BITS_0  = 4'h8;
   localparam logic [3:0] TX_BITS_8  = 4'ha;
   localparam logic [3:0] TX_BITS_9  = 4'hb;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ufa_bus_req_t;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'h1,
      RX_START = 4'h2,
      RX_DATA  = 4'h4,
      RX_STOP  = 4'h8
   } ufa_rx_state_t;
endpackage

// file: core/ufa_serial.sv
// serial port receiver with stop-bit check and address recognition
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ufa_serial (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   // register port
   input  wire logic [2:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // bit-rate enables, one per direction
   input  wire logic       rx_tick_i,
   input  wire logic       tx_tick_i,
   // serial line
   input  wire logic       rxd_i,
   output logic            txd_o
);
   typedef struct packed {
      logic                   serial_mode_bit_low;
      logic                   serial_mode_bit_high;
      logic                   multidrop_enable;
      logic                   rx_enable;
      logic                   tx_ninth;
      logic                   rx_ninth;
      logic                   transmit_done_flag;
      logic                   receive_done_flag;
      logic                   stop_bit_error_flag;
      logic                   frame_check_enable;
      logic [7:0]             node_address;
      logic [7:0]             node_address_mask;
      logic [7:0]             rx_buffer;
      logic [7:0]             rdata;
      ufa_pkg::ufa_rx_state_t rx_st;
      logic [3:0]             cnt;
      logic [3:0]             idx;
      logic [8:0]             shreg;
   } ufa_state_t;

   ufa_state_t            s;
   ufa_state_t            next_s;
   ufa_pkg::ufa_bus_req_t bus;
   logic                  mode0;
   logic                  mode1;
   logic                  nine;
   logic                  md_on;
   logic                  bit_end;
   logic [8:0]            shifted;
   logic [8:0]            frame;
   logic [7:0]            rx_byte;
   logic [3:0]            last_idx;
   logic                  flag_ok;
   logic                  addr_hit;
   logic                  accept;
   logic                  data_smp;
   logic                  last_smp;
   logic                  stop_smp;
   logic                  early;
   logic                  late;
   logic                  deliver;
   logic                  fe_set;
   logic                  ctrl_wr;
   logic                  tx_go;
   logic                  tx_done;

   assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   ////////////////////////////////////////////////////////////////////////////
   // receive decode

   assign mode0    = !s.serial_mode_bit_low && !s.serial_mode_bit_high;
   assign mode1    = !s.serial_mode_bit_low && s.serial_mode_bit_high;
   assign nine     = s.serial_mode_bit_low;
   // shift mode has no address filtering at all
   assign md_on    = s.multidrop_enable && !mode0;
   assign bit_end  = rx_tick_i && (s.cnt == ufa_pkg::LAST_TICK);
   assign shifted  = {rxd_i, s.shreg[8:1]};
   assign frame    = (s.rx_st == ufa_pkg::RX_STOP) ? s.shreg : shifted;
   assign rx_byte  = nine ? frame[7:0] : frame[8:1];
   assign last_idx = nine ? ufa_pkg::LAST_BIT9 : ufa_pkg::LAST_BIT8;
   // mode 1 takes the stop bit as the address marker
   assign flag_ok  = mode1 ? rxd_i : frame[8];
   assign accept   = !s.receive_done_flag && (!md_on || (flag_ok && addr_hit));
   assign data_smp = (s.rx_st == ufa_pkg::RX_DATA) && (mode0 ? rx_tick_i : bit_end);
   assign last_smp = data_smp && (s.idx == last_idx);
   assign stop_smp = (s.rx_st == ufa_pkg::RX_STOP) && bit_end;
   // done flag moves to the stop bit when checking outside shift mode, or with mode-1 addressing
   assign early    = last_smp && (mode0 || (!s.frame_check_enable
                                            && !(mode1 && s.multidrop_enable)));
   assign late     = stop_smp && (s.frame_check_enable || (mode1 && s.multidrop_enable));
   assign deliver  = (early || late) && accept;
   assign fe_set   = stop_smp && s.frame_check_enable && !rxd_i;
   assign ctrl_wr  = bus.wr && (bus.addr == ufa_pkg::REG_CTRL);

   ufa_addr_match u_match (
      .rx_byte_i           (rx_byte),
      .node_address_i      (s.node_address),
      .node_address_mask_i (s.node_address_mask),
      .hit_o               (addr_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_s = s;
      tx_go  = 1'h0;
      // software writes first, hardware sets after so a set wins
      if (bus.wr) begin
         unique case (bus.addr)
            ufa_pkg::REG_CTRL: begin
               // top bit is the error flag while checking is on
               if (s.frame_check_enable) begin
                  next_s.stop_bit_error_flag = bus.wdata[ufa_pkg::CTRL_MODE_LOW];
               end else begin
                  next_s.serial_mode_bit_low = bus.wdata[ufa_pkg::CTRL_MODE_LOW];
               end
               next_s.serial_mode_bit_high = bus.wdata[ufa_pkg::CTRL_MODE_HIGH];
               next_s.multidrop_enable     = bus.wdata[ufa_pkg::CTRL_MULTIDROP];
               next_s.rx_enable            = bus.wdata[ufa_pkg::CTRL_RX_EN];
               next_s.tx_ninth             = bus.wdata[ufa_pkg::CTRL_TX_NINTH];
               next_s.rx_ninth             = bus.wdata[ufa_pkg::CTRL_RX_NINTH];
               next_s.transmit_done_flag   = bus.wdata[ufa_pkg::CTRL_TX_DONE];
               next_s.receive_done_flag    = bus.wdata[ufa_pkg::CTRL_RX_DONE];
            end
            ufa_pkg::REG_DATA: begin
               tx_go = 1'h1;
            end
            ufa_pkg::REG_POWER: begin
               next_s.frame_check_enable = bus.wdata[ufa_pkg::POWER_FRAME_CHECK];
            end
            ufa_pkg::REG_ADDR: begin
               next_s.node_address = bus.wdata;
            end
            ufa_pkg::REG_MASK: begin
               next_s.node_address_mask = bus.wdata;
            end
            default: begin
            end
         endcase
      end

      // receiver, independent of the transmitter
      unique case (s.rx_st)
         ufa_pkg::RX_IDLE: begin
            next_s.cnt = 4'h0;
            next_s.idx = 4'h0;
            if (s.rx_enable && mode0 && !s.receive_done_flag) begin
               next_s.rx_st = ufa_pkg::RX_DATA;
            end else if (s.rx_enable && !mode0 && !rxd_i) begin
               next_s.rx_st = ufa_pkg::RX_START;
            end
         end
         ufa_pkg::RX_START: begin
            if (rx_tick_i) begin
               next_s.cnt = s.cnt + 4'h1;
               // mid-bit recheck rejects glitches on the line
               if (s.cnt == ufa_pkg::MID_TICK) begin
                  next_s.cnt   = 4'h0;
                  next_s.rx_st = rxd_i ? ufa_pkg::RX_IDLE : ufa_pkg::RX_DATA;
               end
            end
         end
         ufa_pkg::RX_DATA: begin
            if (rx_tick_i && !mode0) begin
               next_s.cnt = s.cnt + 4'h1;
            end
            if (data_smp) begin
               next_s.shreg = shifted;
               next_s.idx   = s.idx + 4'h1;
               if (last_smp) begin
                  next_s.rx_st = mode0 ? ufa_pkg::RX_IDLE : ufa_pkg::RX_STOP;
               end
            end
         end
         ufa_pkg::RX_STOP: begin
            if (rx_tick_i) begin
               next_s.cnt = s.cnt + 4'h1;
            end
            if (stop_smp) begin
               next_s.rx_st = ufa_pkg::RX_IDLE;
            end
         end
      endcase

      // hardware sets override a same-cycle software clear
      if (deliver) begin
         next_s.rx_buffer         = rx_byte;
         next_s.rx_ninth          = nine ? frame[8] : rxd_i;
         next_s.receive_done_flag = 1'h1;
      end
      if (fe_set) begin
         next_s.stop_bit_error_flag = 1'h1;
      end
      if (tx_done) begin
         next_s.transmit_done_flag = 1'h1;
      end

      // read data stands only in the cycle after the strobe
      next_s.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            ufa_pkg::REG_CTRL: begin
               next_s.rdata = {s.frame_check_enable ? s.stop_bit_error_flag
                                                    : s.serial_mode_bit_low,
                               s.serial_mode_bit_high, s.multidrop_enable,
                               s.rx_enable, s.tx_ninth, s.rx_ninth,
                               s.transmit_done_flag, s.receive_done_flag};
            end
            ufa_pkg::REG_DATA: begin
               next_s.rdata = s.rx_buffer;
            end
            ufa_pkg::REG_POWER: begin
               next_s.rdata[ufa_pkg::POWER_FRAME_CHECK] = s.frame_check_enable;
            end
            ufa_pkg::REG_ADDR: begin
               next_s.rdata = s.node_address;
            end
            ufa_pkg::REG_MASK: begin
               next_s.rdata = s.node_address_mask;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         // control register and all flags start cleared
         s                   <= '0;
         s.node_address      <= ufa_pkg::ADDR_RESET;
         s.node_address_mask <= ufa_pkg::MASK_RESET;
         s.rx_st             <= ufa_pkg::RX_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_o = s.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // transmitter

   // own tick, so the two directions may differ in rate
   ufa_tx u_tx (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .tick_i  (tx_tick_i),
      .go_i    (tx_go),
      .mode0_i (mode0),
      .nine_i  (nine),
      .data_i  ({s.tx_ninth, bus.wdata}),
      .txd_o   (txd_o),
      .done_o  (tx_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_FE_ON_BAD_STOP: assert property (@(posedge clock_i) disable iff (reset_i)
      (s.rx_st == ufa_pkg::RX_STOP) && bit_end && s.frame_check_enable && !rxd_i
      |=> s.stop_bit_error_flag)
      else $error("bad stop bit did not set error flag");

   AST_FE_STICKY: assert property (@(posedge clock_i) disable iff (reset_i)
      s.stop_bit_error_flag && !ctrl_wr |=> s.stop_bit_error_flag)
      else $error("error flag dropped without a write");

   AST_FE_NEEDS_CHECK: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.stop_bit_error_flag) && !$past(ctrl_wr) |-> $past(s.frame_check_enable))
      else $error("error flag set with checking off");

   AST_DONE_AT_STOP: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.receive_done_flag) && !$past(ctrl_wr) && $past(s.frame_check_enable)
      && !$past(mode0) |-> $past(s.rx_st) == ufa_pkg::RX_STOP)
      else $error("done flag not at stop bit");

   AST_ADDR_FILTER: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.receive_done_flag) && !$past(ctrl_wr) && $past(md_on) |-> $past(addr_hit))
      else $error("done flag set for foreign address");

   AST_MODE1_STOP: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.receive_done_flag) && !$past(ctrl_wr) && $past(mode1)
      && $past(s.multidrop_enable) |-> $past(rxd_i) && $past(stop_smp))
      else $error("mode 1 address frame without valid stop");

   AST_NINTH_ONE: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.receive_done_flag) && !$past(ctrl_wr) && $past(nine) && $past(md_on)
      |-> s.rx_ninth)
      else $error("address frame accepted with ninth bit zero");

   AST_MODE0_IGNORES: assert property (@(posedge clock_i) disable iff (reset_i)
      mode0 && last_smp && !s.receive_done_flag |=> s.receive_done_flag)
      else $error("shift mode frame was filtered");

   AST_FE_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
      ctrl_wr && s.frame_check_enable && !bus.wdata[ufa_pkg::CTRL_MODE_LOW] && !fe_set
      |=> !s.stop_bit_error_flag)
      else $error("error flag clear write had no effect");

   AST_MULTIDROP_MODES: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(s.receive_done_flag) && !$past(ctrl_wr) && $past(s.multidrop_enable)
      && !$past(mode0) |-> $past(addr_hit) && $past(flag_ok))
      else $error("multidrop frame delivered without address marker");

   AST_GIVEN_HIT: assert property (@(posedge clock_i) disable iff (reset_i)
      (rx_byte | ~s.node_address_mask) == (s.node_address | ~s.node_address_mask)
      |-> addr_hit)
      else $error("given address not recognised");

   AST_BCAST_HIT: assert property (@(posedge clock_i) disable iff (reset_i)
      (rx_byte & (s.node_address | s.node_address_mask))
      == (s.node_address | s.node_address_mask) |-> addr_hit)
      else $error("broadcast address not recognised");

   AST_EXACT_ONLY: assert property (@(posedge clock_i) disable iff (reset_i)
      s.node_address_mask == 8'hff && addr_hit
      |-> rx_byte == s.node_address || rx_byte == 8'hff)
      else $error("full mask matched a foreign address");

   // checked one edge late, so an unknown start state before reset does not trip it
   AST_CTRL_RESET: assert property (@(posedge clock_i) reset_i
      |=> {s.serial_mode_bit_low, s.serial_mode_bit_high, s.multidrop_enable, s.rx_enable,
           s.tx_ninth, s.rx_ninth, s.transmit_done_flag, s.receive_done_flag} == 8'h00
          && !s.stop_bit_error_flag)
      else $error("control register not cleared by reset");
endmodule

// file: core/ufa_tx.sv
// serial transmitter, independent of the receiver
`timescale 1ns/1ps
module ufa_tx (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   // bit-rate enable and request
   input  wire logic       tick_i,
   input  wire logic       go_i,
   input  wire logic       mode0_i,
   input  wire logic       nine_i,
   input  wire logic [8:0] data_i,
   // line and completion
   output logic            txd_o,
   output logic            done_o
);
   typedef struct packed {
      logic        busy;
      logic        mode0;
      logic [10:0] shreg;
      logic [3:0]  left;
      logic [3:0]  cnt;
      logic        txd;
      logic        done;
   } ufa_tx_state_t;

   ufa_tx_state_t s;
   ufa_tx_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'h0;
      // a request while busy is dropped
      if (go_i && !s.busy) begin
         next_s.busy  = 1'h1;
         next_s.cnt   = 4'h0;
         next_s.mode0 = mode0_i;
         if (mode0_i) begin
            next_s.shreg = {3'h7, data_i[7:0]};
            next_s.left  = ufa_pkg::TX_BITS_0;
         end else begin
            next_s.shreg = {1'h1, nine_i ? data_i[8] : 1'h1, data_i[7:0], 1'h0};
            next_s.left  = nine_i ? ufa_pkg::TX_BITS_9 : ufa_pkg::TX_BITS_8;
         end
      end else if (s.busy && tick_i) begin
         next_s.cnt = s.cnt + 4'h1;
         if (s.mode0 || s.cnt == ufa_pkg::LAST_TICK) begin
            next_s.cnt   = 4'h0;
            next_s.shreg = {1'h1, s.shreg[10:1]};
            next_s.left  = s.left - 4'h1;
            if (s.left == 4'h1) begin
               next_s.busy = 1'h0;
               next_s.done = 1'h1;
            end
         end
      end
      next_s.txd = next_s.busy ? next_s.shreg[0] : 1'h1;
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s     <= '0;
         s.txd <= 1'h1;
      end else begin
         s <= next_s;
      end
   end

   assign txd_o  = s.txd;
   assign done_o = s.done;
endmodule

// file: dv/tb_uart_frame_check_and_addr_match.sv
// self-checking bench of the serial receiver with address recognition
`timescale 1ns/1ps
module tb_uart_frame_check_and_addr_match;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] addr;
      logic [7:0] mask;
      logic [7:0] data;
      logic       nine;
      logic       b8;
      logic       stop;
      logic       done;
   } ufa_row_t;

   logic       clock_i     = 1'b0;
   logic       reset_i     = 1'b1;
   logic [2:0] reg_addr_i  = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i    = 1'b0;
   logic       reg_rd_i    = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       rx_tick_i   = 1'b0;
   logic       tx_tick_i   = 1'b0;
   logic [1:0] tx_cnt      = 2'h0;
   logic       rxd_i;
   logic       txd_o;
   logic [7:0] rv;
   logic [9:0] tx_frame    = {1'b1, 8'hA5, 1'b0};
   int         errors      = 0;
   int         checks      = 0;

   // ctrl, address, mask, byte, has ninth, ninth, stop, expected done
   ufa_row_t rows [14] = '{
      '{8'hB0, 8'h56, 8'hFC, 8'h57, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hF0, 8'h56, 8'hFC, 8'h5E, 1'b1, 1'b1, 1'b1, 1'b0},
      '{8'hB0, 8'h56, 8'hFC, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hF0, 8'hF1, 8'hFA, 8'hF0, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hB0, 8'hF3, 8'hF9, 8'hF0, 1'b1, 1'b1, 1'b1, 1'b0},
      '{8'hF0, 8'hF3, 8'hFD, 8'hF1, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hB0, 8'hF1, 8'hFA, 8'hFB, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hF0, 8'hF3, 8'hFF, 8'hF3, 1'b1, 1'b1, 1'b1, 1'b1},
      '{8'hB0, 8'hF3, 8'hFF, 8'hF2, 1'b1, 1'b1, 1'b1, 1'b0},
      '{8'hB0, 8'hF3, 8'hFF, 8'hF3, 1'b1, 1'b0, 1'b1, 1'b0},
      '{8'h70, 8'hF3, 8'hFF, 8'hF3, 1'b0, 1'b0, 1'b1, 1'b1},
      '{8'h70, 8'hF3, 8'hFF, 8'hF3, 1'b0, 1'b0, 1'b0, 1'b0},
      '{8'h70, 8'hF3, 8'hFF, 8'hF2, 1'b0, 1'b0, 1'b1, 1'b0},
      '{8'h90, 8'hF3, 8'hFF, 8'hF2, 1'b1, 1'b0, 1'b1, 1'b1}
   };

   ////////////////////////////////////////////////////////////
   always #10 clock_i = ~clock_i;

   // different rates per direction keep the two sides apart
   always @(posedge clock_i) begin
      rx_tick_i <= ~rx_tick_i;
      tx_cnt    <= (tx_cnt == 2'h2) ? 2'h0 : tx_cnt + 2'h1;
      tx_tick_i <= (tx_cnt == 2'h2);
   end

   ufa_serial DUT (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .reg_rd_i    (reg_rd_i),
      .reg_rdata_o (reg_rdata_o),
      .rx_tick_i   (rx_tick_i),
      .tx_tick_i   (tx_tick_i),
      .rxd_i       (rxd_i),
      .txd_o       (txd_o)
   );

   ufa_node_model node (
      .clock_i (clock_i),
      .tick_i  (rx_tick_i),
      .rxd_o   (rxd_i)
   );

   ////////////////////////////////////////////////////////////
   // strobes drop at the taking edge; next task waits an edge first
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // reads control between last data sample (136) and stop sample (152)
   task automatic mid_frame(input logic [7:0] d, input logic stop);
      fork
         node.send(d, 1'b0, 1'b0, stop);
         begin
            repeat (144) @(posedge clock_i iff rx_tick_i);
            rd_reg(ufa_pkg::REG_CTRL, rv);
         end
      join
      // a low stop bit reads as a fresh start; let that phantom frame run out
      if (!stop) begin
         repeat (160) @(posedge clock_i iff rx_tick_i);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      #(40000 * 20);
      errors++;
      finish_test();
   end

   initial begin
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(ufa_pkg::REG_ADDR, rows[i].addr);
         wr_reg(ufa_pkg::REG_MASK, rows[i].mask);
         wr_reg(ufa_pkg::REG_CTRL, rows[i].ctrl);
         node.send(rows[i].data, rows[i].nine, rows[i].b8, rows[i].stop);
         rd_reg(ufa_pkg::REG_CTRL, rv);
         chk("row done", {7'h00, rows[i].done}, {7'h00, rv[0]});
         if (rows[i].done) begin
            rd_reg(ufa_pkg::REG_DATA, rv);
            chk("row data", rows[i].data, rv);
         end
         // the line still low after a bad stop starts a phantom frame
         if (!rows[i].stop) begin
            repeat (160) @(posedge clock_i iff rx_tick_i);
         end
      end
      // shift mode ignores multidrop, so a non-matching byte still lands
      wr_reg(ufa_pkg::REG_CTRL, 8'h00);
      node.hold(1'b0);
      wr_reg(ufa_pkg::REG_CTRL, 8'h30);
      repeat (20) @(posedge clock_i iff rx_tick_i);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("shift done", 8'h01, rv & 8'h01);
      rd_reg(ufa_pkg::REG_DATA, rv);
      chk("shift data", 8'h00, rv);
      wr_reg(ufa_pkg::REG_CTRL, 8'h00);
      node.hold(1'b1);
      // transmit and receive overlap at unrelated rates
      wr_reg(ufa_pkg::REG_CTRL, 8'h50);
      wr_reg(ufa_pkg::REG_DATA, 8'hA5);
      fork
         node.send(8'h5A, 1'b0, 1'b0, 1'b1);
         begin
            repeat (8) @(posedge clock_i iff tx_tick_i);
            for (int k = 0; k < 10; k++) begin
               #1 chk("txd", {7'h00, tx_frame[k]}, {7'h00, txd_o});
               repeat (16) @(posedge clock_i iff tx_tick_i);
            end
         end
      join
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("both done", 8'h03, rv & 8'h03);
      rd_reg(ufa_pkg::REG_DATA, rv);
      chk("rx beside tx", 8'h5A, rv);
      // stop-bit checking
      wr_reg(ufa_pkg::REG_CTRL, 8'h50);
      mid_frame(8'h3C, 1'b0);
      chk("done at last bit", 8'h01, rv & 8'h01);
      wr_reg(ufa_pkg::REG_POWER, 8'h40);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("error while off", 8'h00, rv & 8'h80);
      wr_reg(ufa_pkg::REG_CTRL, 8'h50);
      mid_frame(8'h3C, 1'b0);
      chk("done before stop", 8'h00, rv & 8'h01);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("error and done", 8'h81, rv & 8'h81);
      wr_reg(ufa_pkg::REG_CTRL, 8'hD0);
      mid_frame(8'hC3, 1'b1);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("sticky error", 8'h81, rv & 8'h81);
      wr_reg(ufa_pkg::REG_CTRL, 8'h50);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("error cleared", 8'h00, rv & 8'h80);
      mid_frame(8'h3C, 1'b0);
      // reset in mid-run clears every register, error flag included
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      wr_reg(3'h5, 8'hFF);
      for (int r = 0; r < 6; r++) begin
         rd_reg(3'(r), rv);
         chk("reset value", 8'h00, rv);
      end
      wr_reg(ufa_pkg::REG_POWER, 8'h40);
      rd_reg(ufa_pkg::REG_CTRL, rv);
      chk("error after reset", 8'h00, rv);
      finish_test();
   end
endmodule

// file: dv/ufa_node_model.sv
// far-side serial node model that drives frames onto the receive line
`timescale 1ns/1ps
module ufa_node_model (
   // clock and receive bit-rate enable
   input  wire logic clock_i,
   input  wire logic tick_i,
   // line toward the block
   output logic      rxd_o
);
   // an idle asynchronous line rests high
   initial rxd_o = 1'b1;

   ////////////////////////////////////////////////////////////
   // one bit slot is 16 receive ticks, so samples land mid-bit
   task automatic slot(input logic b);
      rxd_o <= b;
      repeat (16) @(posedge clock_i iff tick_i);
   endtask

   // the caller picks the address byte to suit the nodes it targets
   task automatic send(input logic [7:0] d, input logic nine, input logic b8,
                       input logic stop);
      @(posedge clock_i iff tick_i);
      slot(1'b0);
      for (int i = 0; i < 8; i++) begin
         slot(d[i]);
      end
      if (nine) begin
         slot(b8);
      end
      slot(stop);
      slot(1'b1);
   endtask

   // static level, used for the shift mode
   task automatic hold(input logic b);
      @(posedge clock_i);
      rxd_o <= b;
   endtask
endmodule
